// File: hdl/or_exec_pkg.sv
package or_exec_pkg;

    // ************************************************************
    // Encodings
    // ************************************************************
    localparam logic [7:0] OPC_OR_LITERAL   = 8'h09;
    localparam logic [5:0] OPC_OR_FILE      = 6'h04;
    localparam int         POS_DEST_BIT     = 9;
    localparam int         POS_BANK_BIT     = 8;
    localparam logic [7:0] INDEXED_MAX_ADDR = 8'h5f;
    localparam logic [3:0] ACCESS_BANK_LOW  = 4'h0;
    localparam logic [3:0] ACCESS_BANK_HIGH = 4'hf;
    localparam logic [7:0] ACCESS_SPLIT     = 8'h60;
    localparam logic [7:0] ACC_RESET        = 8'h00;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} phase_t;

    typedef struct packed {
        logic        wr_en;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } mem_wr_t;

    typedef struct packed {
        logic negative;
        logic zero;
    } flags_t;
endpackage

// File: hdl/or_decode.sv
`timescale 1ns/1ps
module or_decode
    import or_exec_pkg::*;
(
    input  wire logic [15:0] instr_i,
    input  wire logic        ext_set_i,
    input  wire logic [3:0]  bank_select_pointer_i,
    input  wire logic [11:0] index_base_i,
    output logic             is_literal_o,
    output logic             is_file_o,
    output logic             dest_file_o,
    output logic [11:0]      addr_o
);
    logic bank_bit;
    logic [7:0] f;

    always_comb begin
        bank_bit     = instr_i[POS_BANK_BIT];
        f            = instr_i[7:0];
        is_literal_o = (instr_i[15:8] == OPC_OR_LITERAL);
        is_file_o    = (instr_i[15:10] == OPC_OR_FILE);
        dest_file_o  = instr_i[POS_DEST_BIT];
        if (!bank_bit && ext_set_i && f <= INDEXED_MAX_ADDR) begin
            addr_o = 12'(index_base_i + {4'h0, f});
        end else if (!bank_bit) begin
            // Low part of access bank is bank 0, high part is the SFR page
            addr_o = {(f < ACCESS_SPLIT) ? ACCESS_BANK_LOW : ACCESS_BANK_HIGH, f};
        end else begin
            addr_o = {bank_select_pointer_i, f};
        end
    end
endmodule

// File: hdl/or_exec.sv
`timescale 1ns/1ps
module or_exec
    import or_exec_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        instr_valid_i,
    input  wire logic [15:0] instr_i,
    input  wire logic        ext_set_i,
    input  wire logic [3:0]  bank_select_pointer_i,
    input  wire logic [11:0] index_base_i,
    input  wire logic [7:0]  mem_rdata_i,
    output logic [11:0]      mem_raddr_o,
    output logic             mem_rd_o,
    output mem_wr_t          mem_wr_o,
    output logic [7:0]       acc_o,
    output flags_t           flags_o,
    output logic             flags_we_o,
    output logic             busy_o
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        phase_t      ph;
        logic        lit;
        logic        file;
        logic        dfile;
        logic [11:0] addr;
        logic [7:0]  opnd;
        logic [7:0]  res;
        logic [7:0]  acc;
        flags_t      flg;
        logic        fwe;
        mem_wr_t     wr;
    } st_t;

    st_t s_q, s_d;
    logic dec_lit, dec_file, dec_dfile;
    logic [11:0] dec_addr;

    or_decode u_dec (
        .instr_i               (instr_i),
        .ext_set_i             (ext_set_i),
        .bank_select_pointer_i (bank_select_pointer_i),
        .index_base_i          (index_base_i),
        .is_literal_o          (dec_lit),
        .is_file_o             (dec_file),
        .dest_file_o           (dec_dfile),
        .addr_o                (dec_addr)
    );

    // ************************************************************
    // Phase sequencer
    // ************************************************************
    always_comb begin
        s_d          = s_q;
        s_d.fwe      = 1'b0;
        s_d.wr.wr_en = 1'b0;
        unique case (s_q.ph)
            PH_DECODE: begin
                // Instruction is sampled only here; other phases ignore it
                s_d.lit   = instr_valid_i && dec_lit;
                s_d.file  = instr_valid_i && dec_file;
                s_d.dfile = dec_dfile;
                s_d.addr  = dec_addr;
                s_d.opnd  = instr_i[7:0];
                s_d.ph    = PH_READ;
            end
            PH_READ: begin
                if (s_q.file) begin
                    s_d.opnd = mem_rdata_i;
                end
                s_d.ph = PH_PROCESS;
            end
            PH_PROCESS: begin
                s_d.res = s_q.acc | s_q.opnd;
                s_d.ph  = PH_WRITE;
            end
            PH_WRITE: begin
                if (s_q.lit || (s_q.file && !s_q.dfile)) begin
                    s_d.acc = s_q.res;
                end
                if (s_q.file && s_q.dfile) begin
                    s_d.wr = '{wr_en: 1'b1, addr: s_q.addr, wdata: s_q.res};
                end
                if (s_q.lit || s_q.file) begin
                    // Only N and Z move; other status bits are left to the core
                    s_d.flg = '{negative: s_q.res[7], zero: (s_q.res == 8'h00)};
                    s_d.fwe = 1'b1;
                end
                s_d.ph = PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q     <= '0;
            s_q.ph  <= PH_DECODE;
            s_q.acc <= ACC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign mem_raddr_o = s_q.addr;
    assign mem_rd_o    = (s_q.ph == PH_READ) && s_q.file;
    assign mem_wr_o    = s_q.wr;
    assign acc_o       = s_q.acc;
    assign flags_o     = s_q.flg;
    assign flags_we_o  = s_q.fwe;
    assign busy_o      = (s_q.ph != PH_DECODE);

    // ************************************************************
    // Checks
    // ************************************************************
    property p_lit_result;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.ph == PH_DECODE && instr_valid_i && instr_i[15:8] == OPC_OR_LITERAL)
        |-> ##4 (acc_o == ($past(acc_o, 4) | $past(instr_i[7:0], 4)));
    endproperty
    a_lit_result: assert property (p_lit_result) else $error("literal OR wrong");

    property p_four_phases;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.ph == PH_DECODE) |-> ##4 (s_q.ph == PH_DECODE);
    endproperty
    a_four_phases: assert property (p_four_phases) else $error("cycle not 4 phases");

    property p_file_dest_mem;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.ph == PH_DECODE && instr_valid_i && dec_file && dec_dfile)
        |-> ##4 (mem_wr_o.wr_en && $stable(acc_o));
    endproperty
    a_file_dest_mem: assert property (p_file_dest_mem) else $error("no write back");

    property p_file_dest_acc;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.ph == PH_DECODE && instr_valid_i && dec_file && !dec_dfile)
        |-> ##4 (!mem_wr_o.wr_en && flags_we_o);
    endproperty
    a_file_dest_acc: assert property (p_file_dest_acc) else $error("bad acc dest");

    property p_zero_flag;
        @(posedge clk_i) disable iff (rst_i)
        flags_we_o |-> (mem_wr_o.wr_en
            ? ((flags_o.zero == (mem_wr_o.wdata == 8'h00))
               && (flags_o.negative == mem_wr_o.wdata[7]))
            : ((flags_o.zero == (acc_o == 8'h00)) && (flags_o.negative == acc_o[7])));
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("flag mismatch");

    property p_file_decode;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.ph == PH_DECODE && instr_valid_i && instr_i[15:10] == OPC_OR_FILE)
        |-> ##1 mem_rd_o;
    endproperty
    a_file_decode: assert property (p_file_decode) else $error("no operand read");

    property p_lit_decode;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.ph == PH_DECODE && instr_valid_i && instr_i[15:8] == OPC_OR_LITERAL)
        |-> ##1 (!mem_rd_o ##3 (flags_we_o && !mem_wr_o.wr_en));
    endproperty
    a_lit_decode: assert property (p_lit_decode) else $error("literal misdecoded");

    property p_indexed;
        @(posedge clk_i) disable iff (rst_i)
        (!instr_i[POS_BANK_BIT] && ext_set_i && instr_i[7:0] <= INDEXED_MAX_ADDR)
        |-> (dec_addr == 12'(index_base_i + {4'h0, instr_i[7:0]}));
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_banked;
        @(posedge clk_i) disable iff (rst_i)
        instr_i[POS_BANK_BIT] |-> (dec_addr[11:8] == bank_select_pointer_i);
    endproperty
    a_banked: assert property (p_banked) else $error("bank pointer unused");

    property p_access_bank;
        @(posedge clk_i) disable iff (rst_i)
        (!instr_i[POS_BANK_BIT] && !(ext_set_i && instr_i[7:0] <= INDEXED_MAX_ADDR))
        |-> (dec_addr[7:0] == instr_i[7:0])
            && ((instr_i[7:0] < ACCESS_SPLIT) ? (dec_addr[11:8] == ACCESS_BANK_LOW)
                                              : (dec_addr[11:8] == ACCESS_BANK_HIGH));
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

    property p_file_acc;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.ph == PH_DECODE && instr_valid_i && dec_file && !dec_dfile)
        |-> ##4 (acc_o == ($past(acc_o, 4) | $past(mem_rdata_i, 3)));
    endproperty
    a_file_acc: assert property (p_file_acc) else $error("acc result wrong");

    property p_file_wb;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.ph == PH_DECODE && instr_valid_i && dec_file && dec_dfile)
        |-> ##4 ((mem_wr_o.wdata == ($past(acc_o, 4) | $past(mem_rdata_i, 3)))
                 && (mem_wr_o.addr == $past(mem_raddr_o, 3)));
    endproperty
    a_file_wb: assert property (p_file_wb) else $error("write back data wrong");

    property p_refused;
        @(posedge clk_i) disable iff (rst_i)
        (s_q.ph == PH_DECODE && !(instr_valid_i && (dec_lit || dec_file)))
        |-> ##1 (!mem_rd_o ##3 ($stable(acc_o) && !flags_we_o && !mem_wr_o.wr_en));
    endproperty
    a_refused: assert property (p_refused) else $error("refused word acted on");

    property p_flags_pulse;
        @(posedge clk_i) disable iff (rst_i)
        flags_we_o |=> (!flags_we_o && !mem_wr_o.wr_en);
    endproperty
    a_flags_pulse: assert property (p_flags_pulse) else $error("pulse too long");

    // ************************************************************
    // Coverage
    // ************************************************************
    c_lit:   cover property (@(posedge clk_i) disable iff (rst_i)
        s_q.ph == PH_WRITE && s_q.lit);
    c_wb:    cover property (@(posedge clk_i) disable iff (rst_i) mem_wr_o.wr_en);
    c_zero:  cover property (@(posedge clk_i) disable iff (rst_i) flags_we_o && flags_o.zero);
    c_index: cover property (@(posedge clk_i) disable iff (rst_i)
        s_q.ph == PH_DECODE && !instr_i[POS_BANK_BIT] && ext_set_i && instr_valid_i);
endmodule

// File: verification/or_mem_model.sv
`timescale 1ns/1ps
// ****************************************
// Data memory beside the core
// ****************************************
module or_mem_model
    import or_exec_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic [11:0] mem_raddr_i,
    input  wire logic        mem_rd_i,
    input  wire mem_wr_t     mem_wr_i,
    output logic [7:0]       mem_rdata_o
);
    logic [7:0] mem [4096];
    logic [7:0] last_q;
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
        end
        last_q = 8'h00;
    end
    // Released line shows the inverse of the last byte, never a stale match
    assign mem_rdata_o = mem_rd_i ? mem[mem_raddr_i] : ~last_q;
    always @(posedge clk_i) begin
        if (mem_rd_i) last_q <= mem[mem_raddr_i];
        if (mem_wr_i.wr_en) mem[mem_wr_i.addr] <= mem_wr_i.wdata;
    end
endmodule

// File: verification/test_inclusive_or_instruction_exec.sv
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module test_inclusive_or_instruction_exec;
    import or_exec_pkg::*;
    logic clk_i = 0, rst_i = 1, v_i = 0, ext_i = 0;
    logic [15:0] instr_i = 16'h0000;
    logic [3:0]  bsp_i = 4'h0;
    logic [11:0] base_i = 12'h000, raddr_o;
    logic [7:0]  rdata, acc_o;
    logic        rd_o, we_o, busy_o;
    mem_wr_t     wr_o;
    flags_t      flags_o;
    int err_total = 0, n_checks = 0, cycles = 0;
    always #4 clk_i = ~clk_i;
    or_exec uut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(v_i), .instr_i(instr_i),
        .ext_set_i(ext_i), .bank_select_pointer_i(bsp_i), .index_base_i(base_i),
        .mem_rdata_i(rdata), .mem_raddr_o(raddr_o), .mem_rd_o(rd_o), .mem_wr_o(wr_o),
        .acc_o(acc_o), .flags_o(flags_o), .flags_we_o(we_o), .busy_o(busy_o));
    or_mem_model mem (.clk_i(clk_i), .mem_raddr_i(raddr_o), .mem_rd_i(rd_o),
        .mem_wr_i(wr_o), .mem_rdata_o(rdata));
    task complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            err_total++;
            complete_run();
        end
    end
    task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (e !== g) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] init_byte(input logic [11:0] a);
        return a[7:0] ^ 8'h5a;
    endfunction
    task do_reset;
        rst_i = 1;
        repeat (5) @(negedge clk_i);
        rst_i = 0;
        chk("acc", 12'(ACC_RESET), 12'(acc_o));
        chk("flags", 12'h000, 12'(flags_o));
    endtask
    // One word per instruction; results checked when the phases wrap round
    task automatic exec(input logic v, input logic [15:0] w, input logic rd,
        input logic [11:0] ad, input logic [7:0] acc, input logic [7:0] dat,
        input logic we, input logic wr);
        int n = 0;
        logic [7:0] r;
        // Flags follow the result wherever it lands
        r = wr ? dat : acc;
        while (busy_o !== 1'b0 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        v_i = v;
        instr_i = w;
        @(posedge clk_i);
        @(negedge clk_i);
        v_i = 0;
        instr_i = 16'hffff;
        chk("busy", 12'h001, 12'(busy_o));
        chk("mem_rd", 12'(rd), 12'(rd_o));
        if (rd) chk("raddr", ad, raddr_o);
        n = 0;
        while (busy_o !== 1'b0 && n < 6) begin
            @(negedge clk_i);
            n++;
        end
        chk("cycles", 12'h003, 12'(n));
        chk("acc", 12'(acc), 12'(acc_o));
        if (we) chk("flags", 12'({r[7], r == 8'h00}), 12'(flags_o));
        chk("flags_we", 12'(we), 12'(we_o));
        chk("wr_en", 12'(wr), 12'(wr_o.wr_en));
        if (wr) chk("waddr", ad, wr_o.addr);
        if (wr) chk("wdata", 12'(dat), 12'(wr_o.wdata));
    endtask
    task test_literal;
        exec(1, 16'h0900, 0, 0, 8'h00, 0, 1, 0);
        exec(1, 16'h099a, 0, 0, 8'h9a, 0, 1, 0);
        exec(1, 16'h0935, 0, 0, 8'hbf, 0, 1, 0);
        exec(1, 16'h09ff, 0, 0, 8'hff, 0, 1, 0);
        $display("literal test done");
    endtask
    task test_refused;
        exec(1, 16'h0a00, 0, 0, 8'hff, 0, 0, 0);
        exec(0, 16'h1110, 0, 0, 8'hff, 0, 0, 0);
        exec(1, 16'h1910, 0, 0, 8'hff, 0, 0, 0);
        $display("refused test done");
    endtask
    task test_file;
        logic [7:0] a;
        do_reset();
        exec(1, 16'h0913, 0, 0, 8'h13, 0, 1, 0);
        bsp_i = 4'h2;
        a = 8'h13 | init_byte(12'h210);
        exec(1, 16'h1110, 1, 12'h210, a, a, 1, 0);
        exec(1, 16'h1270, 1, 12'hf70, a, a | init_byte(12'hf70), 1, 1);
        exec(1, 16'h1220, 1, 12'h020, a, a | init_byte(12'h020), 1, 1);
        ext_i = 1;
        base_i = 12'h300;
        exec(1, 16'h125f, 1, 12'h35f, a, a | init_byte(12'h35f), 1, 1);
        exec(1, 16'h1260, 1, 12'hf60, a, a | init_byte(12'hf60), 1, 1);
        exec(1, 16'h1360, 1, 12'h260, a, a | init_byte(12'h260), 1, 1);
        $display("register test done");
    endtask
    initial begin
        do_reset();
        test_literal();
        test_refused();
        test_file();
        complete_run();
    end
endmodule
